// file: src/edoc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "edoc_map.vh"
module edoc_ctrl #(
  parameter PWRUP_CYC = `EDOC_PWRUP_CYC,
  parameter REF_CYC = `EDOC_REF_CYC,
  parameter WAKE_CNT = `EDOC_WAKE_CNT
) (
  // Clock and reset.
  input wire CLK_IN,
  input wire RSTN_IN,
  // User request port.
  input wire REQ_VALID_IN,
  input wire REQ_WRITE_IN,
  input wire [`EDOC_ROW_W-1:0] REQ_ROW_IN,
  input wire [`EDOC_COL_W-1:0] REQ_COL_IN,
  input wire [1:0] REQ_BYTE_EN_IN,
  input wire [`EDOC_DATA_W-1:0] REQ_WDATA_IN,
  input wire REQ_LAST_IN,
  input wire REFRESH_LATE_IN,
  output reg REQ_READY_OUT,
  output reg RD_VALID_OUT,
  output reg [`EDOC_DATA_W-1:0] RD_DATA_OUT,
  output reg INIT_DONE_OUT,
  // Memory pins.
  output reg ROW_STROBE_N_OUT,
  output reg LOWER_COL_STROBE_N_OUT,
  output reg UPPER_COL_STROBE_N_OUT,
  output reg WRITE_N_OUT,
  output reg OUT_GATE_N_OUT,
  output reg [`EDOC_ROW_W-1:0] MUX_ADDRESS_PINS_OUT,
  input wire [`EDOC_DATA_W-1:0] DATA_PINS_IN,
  output reg [`EDOC_DATA_W-1:0] DATA_PINS_OUT,
  output reg DATA_PINS_OE_N_OUT
);
  // States.
  localparam S_PWRUP = 4'h0;
  localparam S_WAKE = 4'h1;
  localparam S_IDLE = 4'h2;
  localparam S_ROW = 4'h3;
  localparam S_COL = 4'h4;
  localparam S_ACC = 4'h5;
  localparam S_PAGE = 4'h6;
  localparam S_CLOSE = 4'h7;
  localparam S_RF_CAS = 4'h8;
  localparam S_RF_RAS = 4'h9;
  localparam S_RF_END = 4'ha;
  localparam S_PRE = 4'hb;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [24:0] wait_r;
  reg [3:0] wake_r;
  reg ref_pend_r;
  reg wake_mode_r;
  reg is_wr_r;
  reg [`EDOC_ROW_W-1:0] row_r;
  wire ref_tick;

  // Decodes the column strobe pair from byte enables.
  function [1:0] edoc_cas;
    input [1:0] be;
    begin
      edoc_cas = ~be;
    end
  endfunction

  // Periodic refresh request timer.
  edoc_timer #(.WIDTH(16)) u_ref_timer (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .load_in(REF_CYC[15:0] - 16'h0001),
    .restart_in(1'b0),
    .expire_out(ref_tick)
  );

  // Next-state selection.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_PWRUP: begin
        if (wait_r == 25'h0) state_nxt = S_RF_CAS;
      end
      S_IDLE: begin
        if (REFRESH_LATE_IN || ref_pend_r) state_nxt = S_RF_CAS;
        else if (REQ_VALID_IN) state_nxt = S_ROW;
      end
      S_ROW: state_nxt = S_COL;
      S_COL: state_nxt = S_ACC;
      S_ACC: state_nxt = is_wr_r ? S_PAGE : S_PAGE;
      S_PAGE: begin
        if (REQ_LAST_IN || ref_pend_r || !REQ_VALID_IN) state_nxt = S_CLOSE;
        else state_nxt = S_COL;
      end
      S_CLOSE: state_nxt = S_PRE;
      S_RF_CAS: state_nxt = S_RF_RAS;
      S_RF_RAS: state_nxt = S_RF_END;
      S_RF_END: state_nxt = S_PRE;
      S_PRE: begin
        if (wake_mode_r && wake_r != 4'h0) state_nxt = S_RF_CAS;
        else state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Sequencer and pin registers.
  always @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_r <= S_PWRUP;
      wait_r <= PWRUP_CYC[24:0]; // Pause is loaded here so power-up cannot end at once.
      wake_r <= WAKE_CNT[3:0]; // Wake-up burst length is ready before the pause ends.
      wake_mode_r <= 1'b1;
      ref_pend_r <= 1'b0;
      is_wr_r <= 1'b0;
      row_r <= {`EDOC_ROW_W{1'b0}};
      REQ_READY_OUT <= 1'b0;
      RD_VALID_OUT <= 1'b0;
      RD_DATA_OUT <= {`EDOC_DATA_W{1'b0}};
      INIT_DONE_OUT <= 1'b0;
      ROW_STROBE_N_OUT <= 1'b1;
      LOWER_COL_STROBE_N_OUT <= 1'b1;
      UPPER_COL_STROBE_N_OUT <= 1'b1;
      WRITE_N_OUT <= 1'b1;
      OUT_GATE_N_OUT <= 1'b1;
      MUX_ADDRESS_PINS_OUT <= {`EDOC_ROW_W{1'b0}};
      DATA_PINS_OUT <= {`EDOC_DATA_W{1'b0}};
      DATA_PINS_OE_N_OUT <= 1'b1;
    end else begin
      state_r <= state_nxt;
      RD_VALID_OUT <= 1'b0;
      REQ_READY_OUT <= 1'b0;
      // Refresh request latch; tick wins over clear.
      if (ref_tick) ref_pend_r <= 1'b1;
      else if (state_r == S_RF_RAS) ref_pend_r <= 1'b0;
      case (state_r)
        S_PWRUP: begin
          // Power-up pause counts down from its reset load.
          if (wait_r != 25'h0) wait_r <= wait_r - 25'h1;
        end
        S_IDLE: begin
          // Late refresh restarts the wake-up burst.
          if (REFRESH_LATE_IN) begin
            wake_mode_r <= 1'b1;
            wake_r <= WAKE_CNT[3:0];
            INIT_DONE_OUT <= 1'b0;
          end else if (!ref_pend_r && REQ_VALID_IN) begin
            row_r <= REQ_ROW_IN;
            MUX_ADDRESS_PINS_OUT <= REQ_ROW_IN;
          end
        end
        S_ROW: begin
          // Cycle opens on row strobe fall.
          ROW_STROBE_N_OUT <= 1'b0;
        end
        S_COL: begin
          // Column address within the open row.
          MUX_ADDRESS_PINS_OUT <= {2'h0, REQ_COL_IN};
          is_wr_r <= REQ_WRITE_IN;
          REQ_READY_OUT <= 1'b1;
          if (REQ_WRITE_IN) begin
            // Write data and write strobe ahead of column strobe.
            DATA_PINS_OUT <= REQ_WDATA_IN;
            DATA_PINS_OE_N_OUT <= 1'b0;
            WRITE_N_OUT <= 1'b0;
            OUT_GATE_N_OUT <= 1'b1;
          end else begin
            // Read keeps write strobe high, gate low.
            DATA_PINS_OE_N_OUT <= 1'b1;
            WRITE_N_OUT <= 1'b1;
            OUT_GATE_N_OUT <= 1'b0;
          end
        end
        S_ACC: begin
          // Column strobe falls last and starts the access.
          {UPPER_COL_STROBE_N_OUT, LOWER_COL_STROBE_N_OUT} <= edoc_cas(REQ_BYTE_EN_IN);
        end
        S_PAGE: begin
          // Sample a full clock after the column strobe fell.
          // Data is still held while column strobe rises.
          if (!is_wr_r) begin
            RD_DATA_OUT <= DATA_PINS_IN;
            RD_VALID_OUT <= 1'b1;
          end
          // Column strobes rise; next column may be read or write.
          LOWER_COL_STROBE_N_OUT <= 1'b1;
          UPPER_COL_STROBE_N_OUT <= 1'b1;
          WRITE_N_OUT <= 1'b1;
        end
        S_CLOSE: begin
          ROW_STROBE_N_OUT <= 1'b1;
          OUT_GATE_N_OUT <= 1'b1;
          DATA_PINS_OE_N_OUT <= 1'b1;
        end
        S_RF_CAS: begin
          // Column strobes low before the row strobe.
          // Data pins released and output gate high.
          LOWER_COL_STROBE_N_OUT <= 1'b0;
          UPPER_COL_STROBE_N_OUT <= 1'b0;
          WRITE_N_OUT <= 1'b1;
          OUT_GATE_N_OUT <= 1'b1;
          DATA_PINS_OE_N_OUT <= 1'b1;
        end
        S_RF_RAS: begin
          // Address pins are left unchanged; device counts rows.
          // The row strobe pulse refreshes one row.
          ROW_STROBE_N_OUT <= 1'b0;
          if (wake_r != 4'h0) wake_r <= wake_r - 4'h1;
        end
        S_RF_END: begin
          ROW_STROBE_N_OUT <= 1'b1;
          LOWER_COL_STROBE_N_OUT <= 1'b1;
          UPPER_COL_STROBE_N_OUT <= 1'b1;
        end
        S_PRE: begin
          if (wake_mode_r && wake_r == 4'h0) begin
            wake_mode_r <= 1'b0;
            INIT_DONE_OUT <= 1'b1;
          end
        end
        default: begin
          ROW_STROBE_N_OUT <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/edoc_map.vh
`ifndef EDOC_MAP_VH
`define EDOC_MAP_VH
// Clock period in nanoseconds.
`define EDOC_CLK_NS 100
// Power-on pause in microseconds and its cycle count.
`define EDOC_PWRUP_US 200
`define EDOC_PWRUP_CYC ((`EDOC_PWRUP_US * 1000 + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
// Number of wake-up row-strobe cycles.
`define EDOC_WAKE_CNT 8
// Refresh period in milliseconds, rows per period, and spacing in cycles (rounded down).
`define EDOC_REF_MS 64
`define EDOC_REF_ROWS 4096
`define EDOC_REF_CYC ((`EDOC_REF_MS * 1000000 / `EDOC_CLK_NS) / `EDOC_REF_ROWS)
// Address and data widths.
`define EDOC_ROW_W 12
`define EDOC_COL_W 10
`define EDOC_DATA_W 16
// Command codes.
`define EDOC_CMD_READ 1'h0
`define EDOC_CMD_WRITE 1'h1
`endif

// file: src/edoc_timer.v
`timescale 1ns/1ps
`default_nettype none
// Down counter that pulses when it reaches zero and then reloads.
module edoc_timer #(
  parameter WIDTH = 16
) (
  input wire clk_in,
  input wire rstn_in,
  input wire [WIDTH-1:0] load_in,
  input wire restart_in,
  output reg expire_out
);
  reg [WIDTH-1:0] count_r;

  // Count down, pulse and reload at zero, or reload on restart.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_r <= {WIDTH{1'b0}};
      expire_out <= 1'b0;
    end else if (restart_in) begin
      count_r <= load_in;
      expire_out <= 1'b0;
    end else if (count_r == {WIDTH{1'b0}}) begin
      count_r <= load_in;
      expire_out <= 1'b1;
    end else begin
      count_r <= count_r - {{(WIDTH-1){1'b0}}, 1'b1};
      expire_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: dv/edoc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the strobes and handshakes of the controller.
module edoc_ctrl_monitor #(parameter PWRUP_CYC = 2000, parameter WAKE_CNT = 8) (
  input wire logic CLK_IN, RSTN_IN, REQ_READY_OUT, RD_VALID_OUT, INIT_DONE_OUT,
  input wire logic ROW_STROBE_N_OUT, LOWER_COL_STROBE_N_OUT, UPPER_COL_STROBE_N_OUT,
  input wire logic WRITE_N_OUT, OUT_GATE_N_OUT, DATA_PINS_OE_N_OUT
);
  wire ras_n = ROW_STROBE_N_OUT;
  wire cas_n = LOWER_COL_STROBE_N_OUT && UPPER_COL_STROBE_N_OUT;
  logic [15:0] cyc_r;
  logic [7:0] nras_r;
  // Counts cycles since reset and row strobe falls since the last wake-up, both saturating.
  always @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cyc_r <= 16'h0;
      nras_r <= 8'h0;
    end else begin
      cyc_r <= (cyc_r == 16'hffff) ? cyc_r : cyc_r + 16'h1;
      if ($fell(INIT_DONE_OUT)) nras_r <= 8'h0;
      else if ($fell(ras_n) && nras_r != 8'hff) nras_r <= nras_r + 8'h1;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  a_pwrup_pause: assert property (cyc_r < PWRUP_CYC |-> ras_n)
    else $error("row strobe during pause");
  a_wake_count: assert property ($rose(INIT_DONE_OUT) |-> nras_r >= WAKE_CNT)
    else $error("too few wake cycles");
  a_ready_init: assert property (REQ_READY_OUT |-> INIT_DONE_OUT)
    else $error("request before wake-up");
  a_read_latency: assert property (REQ_READY_OUT && WRITE_N_OUT |-> ##2 RD_VALID_OUT)
    else $error("read data late");
  a_write_silent: assert property (REQ_READY_OUT && !WRITE_N_OUT |-> ##2 !RD_VALID_OUT)
    else $error("write returned data");
  a_read_we: assert property (!OUT_GATE_N_OUT && !cas_n |-> WRITE_N_OUT)
    else $error("write strobe low in read");
  a_order_next: assert property ($fell(cas_n) && ras_n |=> $fell(ras_n))
    else $error("refresh order broken");
  a_order_quiet: assert property ($fell(ras_n) && !cas_n |-> DATA_PINS_OE_N_OUT && OUT_GATE_N_OUT)
    else $error("data active in refresh");
  a_wdata_setup: assert property ($fell(cas_n) && !WRITE_N_OUT |-> !DATA_PINS_OE_N_OUT)
    else $error("write data not driven");
  a_no_fight: assert property (!DATA_PINS_OE_N_OUT |-> OUT_GATE_N_OUT)
    else $error("bus contention");
  c_read: cover property (RD_VALID_OUT);
  c_write: cover property (REQ_READY_OUT && !WRITE_N_OUT);
  c_order_ref: cover property ($fell(ras_n) && !cas_n);
endmodule
bind edoc_ctrl edoc_ctrl_monitor #(.PWRUP_CYC(PWRUP_CYC), .WAKE_CNT(WAKE_CNT)) edoc_ctrl_monitor_i (.*);
`default_nettype wire

// file: dv/edoc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory device driven only by its strobes.
module edoc_dram_model (
  input wire logic ras_n, lower_col_strobe_n, upper_col_strobe_n, we_n, oe_n,
  input wire logic [11:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output logic [1:0] drv_en,
  output int ref_cnt
);
  logic [15:0] mem [int];
  logic [11:0] row = 12'h0;
  logic [11:0] ref_row = 12'h0;
  logic [1:0] lane = 2'h0;
  logic order_ref = 1'b0;
  int key;
  initial ref_cnt = 0;
  // output gating: lanes drive only while the gate is open.
  assign drv_en = lane & {2{!oe_n}};
  // row open: takes the row or steps the counter.
  always @(negedge ras_n) begin
    order_ref = !lower_col_strobe_n || !upper_col_strobe_n;
    lane = 2'h0;
    if (order_ref) begin
      ref_row = ref_row + 12'h1;
      ref_cnt++;
    end else row = addr;
  end
  // column access: writes lanes or fetches a word.
  always @(negedge lower_col_strobe_n or negedge upper_col_strobe_n) begin
    if (!ras_n && !order_ref) begin
      key = {row, addr[9:0]};
      if (!mem.exists(key)) mem[key] = 16'h0;
      if (!we_n) begin
        if (!lower_col_strobe_n) mem[key][7:0] = din[7:0];
        if (!upper_col_strobe_n) mem[key][15:8] = din[15:8];
        lane = 2'h0;
      end else begin
        dout = mem[key];
        lane = {!upper_col_strobe_n, !lower_col_strobe_n};
      end
    end
  end
  // release: data holds over a column rise, floats at cycle end.
  always @(posedge ras_n or posedge lower_col_strobe_n or posedge upper_col_strobe_n) begin
    if (ras_n && lower_col_strobe_n && upper_col_strobe_n) lane = 2'h0;
  end
endmodule
`default_nettype wire

// file: dv/tb_edo_dram_cycle_and_refresh.sv
`timescale 1ns/1ps
`default_nettype none
module tb_edo_dram_cycle_and_refresh;
  logic CLK_IN = 0, RSTN_IN = 0, REQ_VALID_IN = 0, REQ_WRITE_IN = 0, REQ_LAST_IN = 0;
  logic REFRESH_LATE_IN = 0, REQ_READY_OUT, RD_VALID_OUT, INIT_DONE_OUT, ROW_STROBE_N_OUT;
  logic LOWER_COL_STROBE_N_OUT, UPPER_COL_STROBE_N_OUT, WRITE_N_OUT, OUT_GATE_N_OUT;
  logic DATA_PINS_OE_N_OUT;
  logic [11:0] REQ_ROW_IN = 12'h0, MUX_ADDRESS_PINS_OUT;
  logic [9:0] REQ_COL_IN = 10'h0;
  logic [1:0] REQ_BYTE_EN_IN = 2'h0, drv_en;
  logic [15:0] REQ_WDATA_IN = 16'h0, RD_DATA_OUT, DATA_PINS_IN, DATA_PINS_OUT, dout, oth;
  logic [15:0] last_bus = 16'h0, old;
  logic [15:0] exp_q [$];
  logic [15:0] ref_mem [int];
  int num_errors = 0, num_checks = 0, cycles = 0, ref_cnt, n0;
  edoc_ctrl #(.PWRUP_CYC(20), .REF_CYC(20), .WAKE_CNT(8)) edoc_ctrl_i (.*);
  edoc_dram_model edoc_dram_model_i (.ras_n(ROW_STROBE_N_OUT),
    .lower_col_strobe_n(LOWER_COL_STROBE_N_OUT),
    .upper_col_strobe_n(UPPER_COL_STROBE_N_OUT), .we_n(WRITE_N_OUT), .oe_n(OUT_GATE_N_OUT),
    .addr(MUX_ADDRESS_PINS_OUT), .din(DATA_PINS_IN), .dout(dout), .drv_en(drv_en), .ref_cnt(ref_cnt));
  // Resolves the data bus; lanes nobody drives show the inverse of the last value.
  assign oth = !DATA_PINS_OE_N_OUT ? DATA_PINS_OUT : ~last_bus;
  assign DATA_PINS_IN = {drv_en[1] ? dout[15:8] : oth[15:8], drv_en[0] ? dout[7:0] : oth[7:0]};
  initial begin
    forever #50 CLK_IN = ~CLK_IN;
  end
  // Remembers the bus, cuts a hang short and compares returned reads in order.
  always @(posedge CLK_IN) begin
    last_bus <= DATA_PINS_IN;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
    if (RD_VALID_OUT === 1'b1) chk("read data", exp_q.pop_front(), RD_DATA_OUT);
  end
  task chk(input string name, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge CLK_IN);
    #10;
  endtask
  // Presents one request and holds it past the access edge that samples byte enables and the page edge that samples last.
  task req(input logic w, input logic [11:0] r, input logic [9:0] c, input logic [1:0] be,
    input logic [15:0] d, input logic last);
    int i;
    {REQ_VALID_IN, REQ_WRITE_IN, REQ_ROW_IN, REQ_COL_IN} = {1'b1, w, r, c};
    {REQ_BYTE_EN_IN, REQ_WDATA_IN, REQ_LAST_IN} = {be, d, last};
    for (i = 0; i < 40 && REQ_READY_OUT !== 1'b1; i++) tick(1);
    chk("request taken", 16'h1, {15'h0, REQ_READY_OUT === 1'b1});
    old = ref_mem.exists({r, c}) ? ref_mem[{r, c}] : 16'h0;
    if (w) ref_mem[{r, c}] = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    else exp_q.push_back(old);
    tick(2);
    if (last) begin
      REQ_VALID_IN = 0;
      REQ_LAST_IN = 0;
      tick(1);
    end
  endtask
  task drain;
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) tick(1);
    chk("reads returned", 16'h0, 16'(exp_q.size()));
  endtask
  task t_init;
    for (int i = 0; i < 200 && INIT_DONE_OUT !== 1'b1; i++) tick(1);
    chk("init done", 16'h1, {15'h0, INIT_DONE_OUT});
    chk("wake refreshes", 16'h1, {15'h0, ref_cnt >= 8});
  endtask
  // page access at both column ends, mixed with reads.
  task t_page;
    req(1, 12'hfff, 10'h0, 2'h3, 16'h1234, 0);
    req(1, 12'hfff, 10'h3ff, 2'h3, 16'h5678, 0);
    req(0, 12'hfff, 10'h0, 2'h3, 16'h0, 0);
    req(0, 12'hfff, 10'h3ff, 2'h3, 16'h0, 1);
    req(0, 12'h0, 10'h0, 2'h3, 16'h0, 1);
    drain();
  endtask
  task t_bytes;
    req(1, 12'h5, 10'h5, 2'h1, 16'h55cd, 0);
    req(1, 12'h5, 10'h5, 2'h2, 16'hef55, 0);
    req(0, 12'h5, 10'h5, 2'h3, 16'h0, 1);
    drain();
  endtask
  // periodic and late refresh, data kept.
  task t_refresh;
    n0 = ref_cnt;
    tick(200);
    chk("refresh rate", 16'h1, {15'h0, ref_cnt - n0 >= 9});
    n0 = ref_cnt;
    REFRESH_LATE_IN = 1;
    tick(3);
    REFRESH_LATE_IN = 0;
    tick(60);
    chk("late burst", 16'h1, {15'h0, ref_cnt - n0 >= 8});
    req(0, 12'hfff, 10'h0, 2'h3, 16'h0, 1);
    drain();
  endtask
  initial begin
    tick(10);
    RSTN_IN = 1;
    t_init();
    t_page();
    t_bytes();
    t_refresh();
    end_sim();
  end
endmodule
`default_nettype wire
